/* File: design/tbt_params.svh */
// Register offsets, field positions, reset values and codes for the 10-bit standard timer.
// Assumes inclusion by bare name from the timer module and bench top module.
`ifndef TBT_PARAMS_SVH
`define TBT_PARAMS_SVH

`define TBT_OFF_CTL0     12'h000
`define TBT_OFF_CTL1     12'h004
`define TBT_OFF_CNT_LO   12'h008
`define TBT_OFF_CNT_HI   12'h00C
`define TBT_OFF_CMPA_LO  12'h010
`define TBT_OFF_CMPA_HI  12'h014
`define TBT_OFF_EVENTS   12'h018
`define TBT_OFF_CAPTURE  12'h01C

`define TBT_CTL0_RST     8'h00
`define TBT_CTL1_RST     8'h00
`define TBT_CMPA_RST     10'h000

`define TBT_C0_PAUSE     7
`define TBT_C0_ON        3
`define TBT_C1_LEVEL     3
`define TBT_C1_INVERT    2
`define TBT_C1_SWAP      1
`define TBT_C1_CLRSEL    0

`define TBT_EV_A         0
`define TBT_EV_P         1
`define TBT_EV_CAP       2

`define TBT_DIV4_LAST    2'h3
`define TBT_DIV16_LAST   4'hF
`define TBT_DIV64_LAST   6'h3F
`define TBT_CNT_MAX      10'h3FF

`endif

/* File: design/tbt_pkg.sv */
// Types for the 10-bit standard timer.
// Assumes tbt_params.svh is on the include path.
package tbt_pkg;

  typedef enum logic [1:0] {
    TBT_MODE_CMP = 2'h0,
    TBT_MODE_CAP = 2'h1,
    TBT_MODE_PWM = 2'h2,
    TBT_MODE_TMR = 2'h3
  } tbt_mode_t;

  typedef enum logic [2:0] {
    TBT_CK_SYS4  = 3'h0,
    TBT_CK_SYS   = 3'h1,
    TBT_CK_H16   = 3'h2,
    TBT_CK_H64   = 3'h3,
    TBT_CK_TBC   = 3'h4,
    TBT_CK_RSVD  = 3'h5,
    TBT_CK_EXTR  = 3'h6,
    TBT_CK_EXTF  = 3'h7
  } tbt_clksel_t;

  typedef struct packed {
    logic        pause_ctl;
    tbt_clksel_t count_clock_sel;
    logic        module_on_ctl;
    logic [2:0]  period_upper_field;
  } tbt_ctl0_t;

  typedef struct packed {
    tbt_mode_t   op_mode_field;
    logic [1:0]  pin_function_field;
    logic        pin_level_ctl;
    logic        pin_invert_ctl;
    logic        period_duty_swap;
    logic        clear_source_sel;
  } tbt_ctl1_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tbt_apb_req_t;

endpackage : tbt_pkg

/* File: design/tbt_timer.sv */
// 10-bit standard timer: count-up counter, comparators A and P, pin logic, APB slave.
// Assumes pins and the high/timebase clock ticks come from outside pclk's domain.
`timescale 1ns/1ns
`default_nettype none
`include "tbt_params.svh"

module tbt_timer (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire tbt_pkg::tbt_apb_req_t apb_req,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              high_clk_tick,
  input  wire logic              timebase_tick,
  input  wire logic              ext_count_input,
  input  wire logic              timer_pin_in,
  output logic                   timer_out_pin_a,
  output logic                   timer_out_pin_b,
  output logic                   timer_pin_oe
);
  import tbt_pkg::*;

  // ****************************************
  // Register bus
  // ****************************************
  tbt_ctl0_t   ctl0_q;
  tbt_ctl1_t   ctl1_q;
  logic [9:0]  cmpa_q;
  logic [2:0]  events_q;
  logic [9:0]  capture_q;
  logic [9:0]  count_q;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        ev_clr_a;
  logic        ev_clr_p;
  logic        ev_clr_c;

  always_comb begin
    unique case (apb_req.paddr)
      `TBT_OFF_CTL0, `TBT_OFF_CTL1, `TBT_OFF_CNT_LO, `TBT_OFF_CNT_HI,
      `TBT_OFF_CMPA_LO, `TBT_OFF_CMPA_HI, `TBT_OFF_EVENTS, `TBT_OFF_CAPTURE: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = apb_req.psel & apb_req.penable & ~addr_ok;
  assign wr_en   = apb_req.psel & apb_req.penable & apb_req.pwrite & addr_ok;
  assign rd_en   = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl0_q <= tbt_ctl0_t'(`TBT_CTL0_RST);
      ctl1_q <= tbt_ctl1_t'(`TBT_CTL1_RST);
    end else if (wr_en && apb_req.paddr == `TBT_OFF_CTL0) begin
      ctl0_q <= tbt_ctl0_t'(apb_req.pwdata[7:0]);
    end else if (wr_en && apb_req.paddr == `TBT_OFF_CTL1) begin
      ctl1_q <= tbt_ctl1_t'(apb_req.pwdata[7:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpa_q <= `TBT_CMPA_RST;
    end else if (wr_en && apb_req.paddr == `TBT_OFF_CMPA_LO) begin
      cmpa_q[7:0] <= apb_req.pwdata[7:0];
    end else if (wr_en && apb_req.paddr == `TBT_OFF_CMPA_HI) begin
      cmpa_q[9:8] <= apb_req.pwdata[1:0];
    end
  end

  // Read data registered in setup, valid in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (apb_req.paddr)
        `TBT_OFF_CTL0:    prdata <= {24'h00_0000, ctl0_q};
        `TBT_OFF_CTL1:    prdata <= {24'h00_0000, ctl1_q};
        `TBT_OFF_CNT_LO:  prdata <= {24'h00_0000, count_q[7:0]};
        `TBT_OFF_CNT_HI:  prdata <= {30'h0000_0000, count_q[9:8]};
        `TBT_OFF_CMPA_LO: prdata <= {24'h00_0000, cmpa_q[7:0]};
        `TBT_OFF_CMPA_HI: prdata <= {30'h0000_0000, cmpa_q[9:8]};
        `TBT_OFF_EVENTS:  prdata <= {29'h0000_0000, events_q};
        `TBT_OFF_CAPTURE: prdata <= {22'h00_0000, capture_q};
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Write one to clear event flags
  assign ev_clr_a = wr_en && apb_req.paddr == `TBT_OFF_EVENTS && apb_req.pwdata[`TBT_EV_A];
  assign ev_clr_p = wr_en && apb_req.paddr == `TBT_OFF_EVENTS && apb_req.pwdata[`TBT_EV_P];
  assign ev_clr_c = wr_en && apb_req.paddr == `TBT_OFF_EVENTS && apb_req.pwdata[`TBT_EV_CAP];

  // ****************************************
  // Synchronisers
  // ****************************************
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [1:0] ext_hist_q;
  logic [1:0] pin_hist_q;
  logic       hclk_prev_q;
  logic       tbc_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {timer_pin_in, ext_count_input, timebase_tick, high_clk_tick};
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_hist_q  <= 2'h0;
      pin_hist_q  <= 2'h0;
      hclk_prev_q <= 1'b0;
      tbc_prev_q  <= 1'b0;
    end else begin
      ext_hist_q  <= {ext_hist_q[0], sync2_q[2]};
      pin_hist_q  <= {pin_hist_q[0], sync2_q[3]};
      hclk_prev_q <= sync2_q[0];
      tbc_prev_q  <= sync2_q[1];
    end
  end

  // ****************************************
  // Count clock selection
  // ****************************************
  logic [1:0] div4_q;
  logic [5:0] hdiv_q;
  logic       hclk_rise;
  logic       tick;

  assign hclk_rise = sync2_q[0] & ~hclk_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div4_q <= 2'h0;
      hdiv_q <= 6'h00;
    end else begin
      div4_q <= div4_q + 2'h1;
      if (hclk_rise) begin
        hdiv_q <= hdiv_q + 6'h01;
      end
    end
  end

  always_comb begin
    unique case (ctl0_q.count_clock_sel)
      TBT_CK_SYS4: tick = (div4_q == `TBT_DIV4_LAST);
      TBT_CK_SYS:  tick = 1'b1;
      TBT_CK_H16:  tick = hclk_rise && (hdiv_q[3:0] == `TBT_DIV16_LAST);
      TBT_CK_H64:  tick = hclk_rise && (hdiv_q == `TBT_DIV64_LAST);
      TBT_CK_TBC:  tick = sync2_q[1] & ~tbc_prev_q;
      TBT_CK_RSVD: tick = 1'b0;
      TBT_CK_EXTR: tick = ext_hist_q[0] & ~ext_hist_q[1];
      TBT_CK_EXTF: tick = ~ext_hist_q[0] & ext_hist_q[1];
    endcase
  end

  // ****************************************
  // Counter and comparators
  // ****************************************
  logic      on_prev_q;
  logic      on_rise;
  logic      run;
  logic      match_a;
  logic      match_p;
  logic      ovf;
  logic      pwm_mode;
  logic      clr_on_a;
  logic      clr_now;
  logic      cap_hit;

  assign on_rise  = ctl0_q.module_on_ctl & ~on_prev_q;
  assign run      = ctl0_q.module_on_ctl & ~ctl0_q.pause_ctl & tick;
  assign match_a  = run && (count_q == cmpa_q);
  assign match_p  = run && (ctl0_q.period_upper_field != 3'h0) &&
                    (count_q[9:7] == ctl0_q.period_upper_field - 3'h1) &&
                    (count_q[6:0] == 7'h7F);
  assign ovf      = run && (count_q == `TBT_CNT_MAX);
  assign pwm_mode = (ctl1_q.op_mode_field == TBT_MODE_PWM);

  // PWM clear follows the swap bit; capture clears on P, or on overflow when the period field is zero
  always_comb begin
    unique case (ctl1_q.op_mode_field)
      TBT_MODE_PWM: clr_on_a = ctl1_q.period_duty_swap;
      TBT_MODE_CAP: clr_on_a = 1'b0;
      default:      clr_on_a = ctl1_q.clear_source_sel;
    endcase
  end

  assign clr_now = clr_on_a ? match_a :
                   ((ctl0_q.period_upper_field == 3'h0) ? ovf : match_p);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_prev_q <= 1'b0;
    end else begin
      on_prev_q <= ctl0_q.module_on_ctl;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 10'h000;
    end else if (on_rise) begin
      count_q <= 10'h000;
    end else if (clr_now) begin
      count_q <= 10'h000;
    end else if (run) begin
      count_q <= count_q + 10'h001;
    end
  end

  // Set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      events_q <= 3'h0;
    end else begin
      events_q[`TBT_EV_A] <= match_a | (events_q[`TBT_EV_A] & ~ev_clr_a);
      events_q[`TBT_EV_P] <= match_p | (events_q[`TBT_EV_P] & ~ev_clr_p);
      events_q[`TBT_EV_CAP] <= cap_hit | (events_q[`TBT_EV_CAP] & ~ev_clr_c);
    end
  end

  // ****************************************
  // Capture
  // ****************************************
  logic pin_r;
  logic pin_f;

  assign pin_r = pin_hist_q[0] & ~pin_hist_q[1];
  assign pin_f = ~pin_hist_q[0] & pin_hist_q[1];

  always_comb begin
    unique case (ctl1_q.pin_function_field)
      2'h0: cap_hit = pin_r;
      2'h1: cap_hit = pin_f;
      2'h2: cap_hit = pin_r | pin_f;
      2'h3: cap_hit = 1'b0;
    endcase
    cap_hit = cap_hit && ctl0_q.module_on_ctl && (ctl1_q.op_mode_field == TBT_MODE_CAP);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_q <= 10'h000;
    end else if (cap_hit) begin
      capture_q <= count_q;
    end
  end

  // ****************************************
  // Output pin
  // ****************************************
  logic cmp_lvl_q;
  logic pulse_q;
  logic duty_on;
  logic pwm_lvl;
  logic raw_lvl;

  // Compare output level; the requested level overwrites, equal level is a no-op
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_lvl_q <= 1'b0;
    end else if (on_rise) begin
      cmp_lvl_q <= ctl1_q.pin_level_ctl;
    end else if (match_a) begin
      unique case (ctl1_q.pin_function_field)
        2'h0: cmp_lvl_q <= cmp_lvl_q;
        2'h1: cmp_lvl_q <= 1'b0;
        2'h2: cmp_lvl_q <= 1'b1;
        2'h3: cmp_lvl_q <= ~cmp_lvl_q;
      endcase
    end
  end

  // Duty compares against counter; duty at or above period gives full duty
  assign duty_on = ctl1_q.period_duty_swap ?
                   (count_q[9:7] < ctl0_q.period_upper_field ||
                    ctl0_q.period_upper_field == 3'h0) :
                   (count_q < cmpa_q);

  // Single pulse: active from on rise until the period clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_q <= 1'b0;
    end else if (on_rise) begin
      pulse_q <= 1'b1;
    end else if (clr_now || !ctl0_q.module_on_ctl) begin
      pulse_q <= 1'b0;
    end
  end

  always_comb begin
    unique case (ctl1_q.pin_function_field)
      2'h0: pwm_lvl = 1'b0;
      2'h1: pwm_lvl = 1'b1;
      2'h2: pwm_lvl = duty_on & ctl0_q.module_on_ctl;
      2'h3: pwm_lvl = pulse_q & duty_on;
    endcase
  end

  always_comb begin
    unique case (ctl1_q.op_mode_field)
      TBT_MODE_CMP: raw_lvl = cmp_lvl_q ^ ctl1_q.pin_invert_ctl;
      TBT_MODE_PWM: raw_lvl = (pwm_lvl ~^ ctl1_q.pin_level_ctl) ^ ctl1_q.pin_invert_ctl;
      default:      raw_lvl = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_out_pin_a <= 1'b0;
      timer_out_pin_b <= 1'b0;
      timer_pin_oe    <= 1'b0;
    end else begin
      timer_out_pin_a <= raw_lvl;
      timer_out_pin_b <= raw_lvl;
      timer_pin_oe    <= pwm_mode || (ctl1_q.op_mode_field == TBT_MODE_CMP);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence on_edge_s;
    $rose(ctl0_q.module_on_ctl);
  endsequence

  on_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    on_edge_s |=> count_q == 10'h000) else $error("counter not cleared on enable");
  hold_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctl0_q.module_on_ctl && !on_rise |=> $stable(count_q)) else $error("counter moved off");
  pause_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctl0_q.pause_ctl && !on_rise |=> $stable(count_q)) else $error("counter moved paused");
  rsvd_clk_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctl0_q.count_clock_sel == TBT_CK_RSVD && !on_rise |=> $stable(count_q))
    else $error("reserved clock advanced counter");
  inc_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    run && !clr_now && !on_rise |=> count_q == $past(count_q) + 10'h001)
    else $error("counter step wrong");
  init_lvl_a: assert property (@(posedge pclk) disable iff (!presetn)
    (on_edge_s and (ctl1_q.op_mode_field == TBT_MODE_CMP)) ##1 $stable(ctl1_q) |=>
    timer_out_pin_a == (ctl1_q.pin_level_ctl ^ ctl1_q.pin_invert_ctl))
    else $error("pin not at initial level");
  evt_a_a: assert property (@(posedge pclk) disable iff (!presetn)
    match_a |=> events_q[`TBT_EV_A]) else $error("A event lost");
  tmr_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctl1_q.op_mode_field == TBT_MODE_TMR |=> !timer_pin_oe && !timer_out_pin_a)
    else $error("pin used in timer mode");
  ovf_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    ovf && !clr_on_a && ctl0_q.period_upper_field == 3'h0 && !on_rise |=> count_q == 10'h000)
    else $error("overflow did not clear");

endmodule : tbt_timer
`default_nettype wire

/* File: dv/tbt_pin_partner.sv */
// Far-side model: external count pin and timer pin input.
// Assumes the bench pclk; each level is held long enough for the input syncs.
`timescale 1ns/1ns
`default_nettype none
module tbt_pin_partner (
  input  wire logic pclk,
  output logic      ext_count_input,
  output logic      timer_pin_in
);
  initial begin
    ext_count_input = 1'b0;
    timer_pin_in    = 1'b0;
  end

  // Whole pulses, w cycles high and w low; idles low between bursts
  task automatic pulses(input int n, input int w);
    repeat (n) begin
      @(posedge pclk) ext_count_input <= 1'b1;
      repeat (w) @(posedge pclk);
      ext_count_input <= 1'b0;
      repeat (w - 1) @(posedge pclk);
    end
  endtask : pulses

  task automatic set_pin(input logic v);
    @(posedge pclk) timer_pin_in <= v;
  endtask : set_pin
endmodule : tbt_pin_partner
`default_nettype wire

/* File: dv/tbt_timer_tb_top.sv */
// Bench for the 10-bit timer: APB master, pin partner, queued result checks.
// Assumes a no-wait-state APB slave and input syncs settling in a few cycles.
`timescale 1ns/1ns
`default_nettype none
`include "tbt_params.svh"
module tbt_timer_tb_top;
  import tbt_pkg::*;
  typedef struct {string nm; logic [32:0] ex; logic [32:0] mk;} tbt_note_t;
  logic         pclk;
  logic         presetn;
  tbt_apb_req_t req;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [1:0]   ticks;
  logic         ext_count_input;
  logic         timer_pin_in;
  logic         pin_a;
  logic         pin_b;
  logic         pin_oe;
  logic         probe_req;
  int           num_errors = 0;
  int           n_checks = 0;
  int           cycles = 0;
  int           n;
  integer       seed;
  logic [9:0]   rv;
  logic [1:0]   capfn[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  logic [11:0]  offs[8] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014,
                          12'h018, 12'h01C};
  tbt_note_t    rd_q[$];
  tbt_note_t    pin_q[$];

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  tbt_timer dut (
    .pclk            (pclk),
    .presetn         (presetn),
    .apb_req         (req),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .high_clk_tick   (ticks[0]),
    .timebase_tick   (ticks[1]),
    .ext_count_input (ext_count_input),
    .timer_pin_in    (timer_pin_in),
    .timer_out_pin_a (pin_a),
    .timer_out_pin_b (pin_b),
    .timer_pin_oe    (pin_oe)
  );

  tbt_pin_partner u_far (
    .pclk            (pclk),
    .ext_count_input (ext_count_input),
    .timer_pin_in    (timer_pin_in)
  );

  // *****
  // Checking
  // *****
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] ex);
    n_checks++;
    if (seen !== ex) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
    end
  endtask : check

  always @(posedge pclk) begin : watch
    tbt_note_t nt;
    if (req.psel && req.penable && pready === 1'b1 && !req.pwrite && rd_q.size() > 0) begin
      nt = rd_q.pop_front();
      check(nt.nm, {pslverr, prdata} & nt.mk, nt.ex);
    end
    if (probe_req && pin_q.size() > 0) begin
      nt = pin_q.pop_front();
      check(nt.nm, {30'h0, pin_oe, pin_a, pin_b} & nt.mk, nt.ex);
    end
  end

  task automatic close_out();
    $display("Checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      close_out();
    end
  end

  // *****
  // Drivers
  // *****
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input string nm, input logic [11:0] a, input logic [32:0] ex);
    rd_q.push_back('{nm, ex, {33{1'b1}}});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic idle(input int c);
    repeat (c) @(posedge pclk);
  endtask : idle

  task automatic probe(input string nm, input logic [2:0] ex, input logic [2:0] mk);
    idle(4);
    pin_q.push_back('{nm, {30'h0, ex}, {30'h0, mk}});
    @(posedge pclk) probe_req <= 1'b1;
    @(posedge pclk) probe_req <= 1'b0;
  endtask : probe

  task automatic tick(input int idx, input int c);
    repeat (c) begin
      @(posedge pclk) ticks[idx] <= 1'b1;
      idle(3);
      ticks[idx] <= 1'b0;
      idle(2);
    end
  endtask : tick

  task automatic cmpa(input logic [9:0] v);
    wr(`TBT_OFF_CMPA_LO, {24'h0, v[7:0]});
    wr(`TBT_OFF_CMPA_HI, {30'h0, v[9:8]});
  endtask : cmpa

  // Mode and pin function change only while off
  task automatic setup(input logic [7:0] c1, input logic [2:0] ck, input logic [2:0] per);
    wr(`TBT_OFF_CTL0, {24'h0, 1'b0, ck, 1'b0, per});
    wr(`TBT_OFF_CTL1, {24'h0, c1});
    wr(`TBT_OFF_EVENTS, 32'h7);
    wr(`TBT_OFF_CTL0, {24'h0, 1'b0, ck, 1'b1, per});
  endtask : setup

  task automatic ev(input logic [9:0] v, input logic [7:0] c1, input logic [2:0] ck,
                    input logic [2:0] per, input int w, input logic [32:0] ex);
    cmpa(v);
    setup(c1, ck, per);
    idle(w);
    rd("events", `TBT_OFF_EVENTS, ex);
  endtask : ev

  // *****
  // Scenarios
  // *****
  initial begin
    presetn   = 1'b0;
    req       = '0;
    ticks     = 2'h0;
    probe_req = 1'b0;
    seed      = 32'h02FB02D0;
    idle(10);
    presetn <= 1'b1;
    foreach (offs[i]) rd("reset", offs[i], 33'h0);
    rd("unmapped", 12'h020, {1'b1, 32'h0});
    repeat (3) begin
      rv = 10'($random(seed));
      wr(`TBT_OFF_CMPA_LO, {24'h0, rv[7:0]});
      wr(`TBT_OFF_CMPA_HI, {24'h0, 6'h3F, rv[9:8]});
      rd("cmpa lo", `TBT_OFF_CMPA_LO, {25'h0, rv[7:0]});
      rd("cmpa hi", `TBT_OFF_CMPA_HI, {31'h0, rv[9:8]});
    end
    $display("Done registers");
    cmpa(10'h3FF);
    for (int k = 2; k < 8; k++) begin
      n = 1 + ($unsigned($random(seed)) % 20);
      setup(8'h00, 3'(k), 3'h0);
      case (k)
        2: tick(0, 32);
        3: tick(0, 128);
        4: tick(1, n);
        5: begin
          tick(0, 64);
          tick(1, n);
          u_far.pulses(n, 3);
        end
        default: u_far.pulses(n, 3 + k % 2);
      endcase
      idle(12);
      n = (k < 4) ? 2 : (k == 5) ? 0 : n;
      rd("count", `TBT_OFF_CNT_LO, 33'(n));
    end
    setup(8'h00, 3'h6, 3'h0);
    u_far.pulses(4, 3);
    wr(`TBT_OFF_CTL0, 32'hE8);
    u_far.pulses(3, 4);
    idle(8);
    rd("paused", `TBT_OFF_CNT_LO, 33'h4);
    wr(`TBT_OFF_CTL0, 32'h68);
    u_far.pulses(2, 3);
    idle(8);
    rd("resumed", `TBT_OFF_CNT_LO, 33'h6);
    wr(`TBT_OFF_CTL0, 32'h60);
    u_far.pulses(3, 3);
    idle(8);
    rd("off", `TBT_OFF_CNT_LO, 33'h6);
    wr(`TBT_OFF_CTL0, 32'h68);
    idle(4);
    rd("on rise", `TBT_OFF_CNT_LO, 33'h0);
    setup(8'h00, 3'h6, 3'h0);
    u_far.pulses(260, 3);
    idle(8);
    rd("count lo", `TBT_OFF_CNT_LO, 33'h04);
    rd("count hi", `TBT_OFF_CNT_HI, 33'h01);
    u_far.pulses(770, 3);
    idle(8);
    rd("overflow", `TBT_OFF_CNT_LO, 33'h06);
    setup(8'h00, 3'h6, 3'h1);
    u_far.pulses(130, 3);
    idle(8);
    rd("period", `TBT_OFF_CNT_LO, 33'h02);
    $display("Done counting");
    ev(10'h3FF, 8'h00, 3'h1, 3'h1, 300, 33'h2);
    ev(10'h200, 8'h00, 3'h1, 3'h0, 1100, 33'h1);
    ev(10'h070, 8'h01, 3'h1, 3'h1, 300, 33'h1);
    ev(10'h070, 8'h81, 3'h1, 3'h1, 300, 33'h3);
    ev(10'h014, 8'h01, 3'h0, 3'h0, 60, 33'h0);
    idle(60);
    rd("events", `TBT_OFF_EVENTS, 33'h1);
    $display("Done events");
    cmpa(10'h032);
    setup(8'h19, 3'h1, 3'h0);
    probe("pin init", 3'h7, 3'h7);
    idle(100);
    probe("pin low", 3'h4, 3'h7);
    wr(`TBT_OFF_CTL0, 32'h10);
    wr(`TBT_OFF_CTL0, 32'h18);
    probe("pin reinit", 3'h7, 3'h7);
    setup(8'h29, 3'h1, 3'h0);
    idle(100);
    probe("pin same", 3'h7, 3'h7);
    setup(8'h31, 3'h1, 3'h0);
    idle(66);
    probe("pin toggle", 3'h7, 3'h7);
    setup(8'h05, 3'h1, 3'h0);
    probe("pin invert", 3'h7, 3'h7);
    setup(8'h98, 3'h1, 3'h0);
    probe("pwm active", 3'h7, 3'h7);
    setup(8'h88, 3'h1, 3'h0);
    probe("pwm inactive", 3'h4, 3'h7);
    setup(8'hF8, 3'h1, 3'h0);
    probe("timer oe", 3'h0, 3'h4);
    cmpa(10'h020);
    setup(8'hA8, 3'h1, 3'h1);
    probe("pwm duty on", 3'h7, 3'h7);
    idle(40);
    probe("pwm duty off", 3'h4, 3'h7);
    setup(8'hB8, 3'h1, 3'h1);
    probe("pulse on", 3'h7, 3'h7);
    idle(140);
    probe("pulse done", 3'h4, 3'h7);
    foreach (capfn[i]) begin
      setup({2'h1, capfn[i], 4'h0}, 3'h1, 3'h0);
      u_far.set_pin(~i[0]);
      idle(10);
      rd("capture", `TBT_OFF_EVENTS, (capfn[i] == 2'h3) ? 33'h0 : 33'h4);
    end
    $display("Done pins");
    idle(4);
    close_out();
  end
endmodule : tbt_timer_tb_top
`default_nettype wire
